// ### rtl/lapb_frame_map.svh
// constants for the link frame engine: codes, field positions, timing
`ifndef LAPB_FRAME_MAP_SVH
`define LAPB_FRAME_MAP_SVH
`define LFE_FLAG 8'h7e
`define LFE_MARK 8'hff
`define LFE_STUFF_RUN 3'h5
`define LFE_UNNUM_EN_BIT 2
`define LFE_PF_MASK 8'h10
`define LFE_CTL_UI 8'h03
`define LFE_CTL_TEST 8'he3
`define LFE_CTL_XID 8'haf
`define LFE_CTL_REJ 8'h09
`define LFE_FCS_INIT 16'hffff
`define LFE_FCS_POLY 16'h8408
`define LFE_FCS_GOOD 16'hf0b8
`define LFE_MIN_OCTETS 15'h0004
`define LFE_MIN_OCTETS_SEQ 15'h0005
`define LFE_COARSE_STEPS 12'h00a
`define LFE_TICK_TIME_NS 100000000
`define LFE_CLOCK_PERIOD_NS 100
`define LFE_TICK_CYCLES (`LFE_TICK_TIME_NS / `LFE_CLOCK_PERIOD_NS)
`endif

// ### rtl/lapb_frame_pkg.sv
// types shared by the link frame engine
package lapb_frame_pkg;
  typedef struct packed {
    logic [7:0]  protocol_option_param;
    logic        mod128;
    logic [7:0]  t1;
    logic [7:0]  t2;
    logic [7:0]  t3;
    logic        t3_coarse;
    logic [6:0]  k;
    logic [13:0] max_info_octets;
    logic [7:0]  n2;
    logic [7:0]  addr_cmd;
    logic [7:0]  addr_rsp;
  } system_parameter_table_t;
  typedef enum logic [1:0] {UN_UI = 2'h0, UN_TEST = 2'h1, UN_XID = 2'h2} unnum_kind_t;
  typedef struct packed {
    unnum_kind_t kind;
    logic        is_cmd;
    logic        pf;
    logic        has_info;
  } unnum_req_t;
  typedef enum logic [2:0] {RK_I = 3'h0, RK_S = 3'h1, RK_UI = 3'h2, RK_TEST = 3'h3, RK_XID = 3'h4,
                            RK_U = 3'h5} rx_kind_t;
  typedef struct packed {
    logic     good;
    logic     undefined;
    logic     overlong;
    rx_kind_t kind;
  } rx_status_t;
  typedef struct packed {
    logic [6:0] vs;
    logic [6:0] va;
    logic [6:0] vr;
  } seq_state_t;
  typedef enum logic [8:0] {
    TX_IDLE  = 9'h001,
    TX_OPEN  = 9'h002,
    TX_ADDR  = 9'h004,
    TX_CTL0  = 9'h008,
    TX_CTL1  = 9'h010,
    TX_INFO  = 9'h020,
    TX_FCS   = 9'h040,
    TX_CLOSE = 9'h080,
    TX_ABORT = 9'h100
  } tx_state_t;
endpackage

// ### rtl/lapb_fcs16.sv
// bit-serial 16-bit hdlc crc register, reflected form
`timescale 1ns/1ps
`include "lapb_frame_map.svh"
module lapb_fcs16 (
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  input  wire logic        i_enable,
  input  wire logic        i_clear,
  input  wire logic        i_shift,
  input  wire logic        i_bit,
  output logic      [15:0] o_crc,
  output logic      [15:0] o_next
);
  wire        fb      = o_crc[0] ^ i_bit;
  wire [15:0] shifted = {1'b0, o_crc[15:1]} ^ (fb ? `LFE_FCS_POLY : 16'h0000);
  assign o_next = i_shift ? shifted : o_crc;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_crc <= `LFE_FCS_INIT;
    end else if (i_enable) begin
      o_crc <= i_clear ? `LFE_FCS_INIT : o_next;
    end
  end
endmodule

// ### rtl/lapb_frame_link_engine.sv
// hdlc link frame engine: framing, fcs, timers and sequence state
`timescale 1ns/1ps
`include "lapb_frame_map.svh"
module lapb_frame_link_engine #(
  parameter int TICK_CYCLES = `LFE_TICK_CYCLES
) (
  input  wire logic                                   i_clock,
  input  wire logic                                   i_rst_n,
  input  wire logic                                   i_enable,
  input  wire lapb_frame_pkg::system_parameter_table_t i_param,
  input  wire logic                                   i_link_setup,
  input  wire logic                                   i_transmit_unnumbered_cmd,
  input  wire lapb_frame_pkg::unnum_req_t              i_unnum_req,
  input  wire logic                                   i_send_info,
  input  wire logic                             [7:0] i_tx_data,
  input  wire logic                                   i_tx_valid,
  input  wire logic                                   i_tx_last,
  output logic                                        o_tx_ready,
  output logic                                        o_tx_idle,
  output logic                                        o_window_open,
  output logic                                        o_txd,
  input  wire logic                                   i_rxd,
  output logic                                  [7:0] o_rx_data,
  output logic                                        o_rx_valid,
  output logic                                        o_rx_end,
  output lapb_frame_pkg::rx_status_t                   o_rx_status,
  output lapb_frame_pkg::seq_state_t                   o_seq,
  output logic                                        o_t1_expired,
  output logic                                        o_t2_expired,
  output logic                                        o_t3_expired,
  output logic                                        o_retry_exhausted
);
  import lapb_frame_pkg::*;

  if (TICK_CYCLES < 2) begin : g_chk
    $error("TICK_CYCLES must be at least 2");
  end
  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

  seq_state_t seq;
  logic       rej_pend;
  // all variables wrap at the modulus
  wire [6:0] mask        = i_param.mod128 ? 7'h7f : 7'h07;
  wire [6:0] outstanding = (seq.vs - seq.va) & mask;
  wire [6:0] k_eff       = (i_param.k > mask) ? mask : i_param.k;
  assign o_seq = seq;
  assign o_window_open = outstanding < k_eff;

  // receive side
  logic [2:0]  ones_rx;
  logic [2:0]  bcnt;
  logic [2:0]  dly_n;
  logic [5:0]  dly;
  logic        in_frame;
  logic [7:0]  bsr;
  logic [7:0]  ctl0;
  logic [7:0]  ctl1;
  logic [7:0]  pipe0;
  logic [7:0]  pipe1;
  logic [1:0]  pipe_n;
  logic [14:0] octets;
  logic        addr_ok;
  logic [15:0] rx_crc;
  rx_kind_t    kind;

  wire abort_ev = i_rxd && ones_rx >= 3'h6;
  wire six_ev   = i_rxd && ones_rx == 3'h5;
  wire flag_ev  = !i_rxd && ones_rx == 3'h6;
  // stuffed zeros and a flag's last two bits never enter
  wire push     = in_frame && ones_rx < `LFE_STUFF_RUN;
  wire data_ev  = push && dly_n == 3'h6;
  wire [7:0] nb = {dly[0], bsr[7:1]};
  wire byte_done = data_ev && bcnt == 3'h7;
  wire has_body  = octets != 15'h0 || bcnt != 3'h0;
  // only a frame opened by a flag can end
  wire frame_end = in_frame && has_body && (flag_ev || abort_ev);

  wire is_i    = !ctl0[0];
  wire is_s    = ctl0[1:0] == 2'b01;
  wire is_u    = ctl0[1:0] == 2'b11;
  wire has_seq = i_param.mod128 && (is_i || is_s);
  wire [7:0] uc = ctl0 & ~`LFE_PF_MASK;
  wire is_ui   = is_u && uc == `LFE_CTL_UI;
  wire is_test = is_u && uc == `LFE_CTL_TEST;
  wire is_xid  = is_u && uc == `LFE_CTL_XID;
  wire [14:0] min_oct = has_seq ? `LFE_MIN_OCTETS_SEQ : `LFE_MIN_OCTETS;
  wire long_ok  = octets >= min_oct;
  wire frame_ok = bcnt == 3'h0 && long_ok && rx_crc == `LFE_FCS_GOOD && addr_ok;
  wire overlong = (octets - min_oct) > {1'b0, i_param.max_info_octets};
  wire undefined = (is_ui || is_test || is_xid) && !i_param.protocol_option_param[`LFE_UNNUM_EN_BIT];
  wire good      = !abort_ev && frame_ok && !overlong && !undefined;
  assign kind = is_i ? RK_I : is_s ? RK_S : is_ui ? RK_UI : is_test ? RK_TEST : is_xid ? RK_XID : RK_U;

  wire [6:0] ns = i_param.mod128 ? ctl0[7:1] : {4'h0, ctl0[3:1]};
  wire [6:0] nr = i_param.mod128 ? ctl1[7:1] : {4'h0, ctl0[7:5]};
  wire rx_ok     = i_enable && frame_end && flag_ev && good;
  wire in_order  = ns == seq.vr;
  // n(r) valid between v(a) and v(s)
  wire nr_ok     = ((nr - seq.va) & mask) <= outstanding;
  wire ack_frame = rx_ok && (is_i || is_s) && nr_ok;
  wire va_adv    = ack_frame && nr != seq.va;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ones_rx  <= 3'h0;
      in_frame <= 1'b0;
      dly      <= 6'h00;
      dly_n    <= 3'h0;
    end else if (i_enable) begin
      ones_rx <= i_rxd ? ((ones_rx == 3'h7) ? 3'h7 : ones_rx + 3'h1) : 3'h0;
      if (flag_ev) begin
        in_frame <= 1'b1;
      end else if (abort_ev) begin
        in_frame <= 1'b0;
      end
      // the six bits held back are the flag's own opening bits
      if (six_ev || flag_ev) begin
        dly_n <= 3'h0;
      end else if (push) begin
        dly   <= {i_rxd, dly[5:1]};
        dly_n <= (dly_n == 3'h6) ? 3'h6 : dly_n + 3'h1;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bsr     <= 8'h00;
      bcnt    <= 3'h0;
      octets  <= 15'h0000;
      addr_ok <= 1'b0;
      ctl0    <= 8'h00;
      ctl1    <= 8'h00;
    end else if (i_enable) begin
      if (flag_ev || abort_ev) begin
        bcnt    <= 3'h0;
        octets  <= 15'h0000;
        addr_ok <= 1'b0;
      end else if (data_ev) begin
        // octets arrive least significant bit first
        bsr  <= nb;
        bcnt <= bcnt + 3'h1;
        if (byte_done && octets != 15'h7fff) octets <= octets + 15'h0001;
        if (byte_done && octets == 15'h0000) addr_ok <= nb == i_param.addr_cmd || nb == i_param.addr_rsp;
        if (byte_done && octets == 15'h0001) ctl0 <= nb;
        if (byte_done && octets == 15'h0002) ctl1 <= nb;
      end
    end
  end

  // two octets held back so the fcs is never handed on
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pipe0       <= 8'h00;
      pipe1       <= 8'h00;
      pipe_n      <= 2'h0;
      o_rx_data   <= 8'h00;
      o_rx_valid  <= 1'b0;
      o_rx_end    <= 1'b0;
      o_rx_status <= '0;
    end else if (i_enable) begin
      o_rx_valid <= byte_done && pipe_n == 2'h2;
      o_rx_end   <= frame_end;
      if (flag_ev || abort_ev) begin
        pipe_n <= 2'h0;
      end else if (byte_done) begin
        pipe0  <= nb;
        pipe1  <= pipe0;
        pipe_n <= (pipe_n == 2'h2) ? 2'h2 : pipe_n + 2'h1;
        if (pipe_n == 2'h2) o_rx_data <= pipe1;
      end
      if (frame_end) o_rx_status <= {good, frame_ok && undefined, frame_ok && overlong, kind};
    end
  end

  // hdlc crc over address, control, info and the received fcs, checked against the good residue
  lapb_fcs16 u_rx_fcs (
    .i_clock  (i_clock),
    .i_rst_n  (i_rst_n),
    .i_enable (i_enable),
    .i_clear  (flag_ev),
    .i_shift  (data_ev),
    .i_bit    (dly[0]),
    .o_crc    (rx_crc),
    .o_next   ()
  );

  // transmit side
  tx_state_t  tx_state;
  tx_state_t  nxt_state;
  logic [7:0] nxt_byte;
  logic       want_info;
  logic [7:0] shreg;
  logic [3:0] bits_left;
  logic [2:0] ones_tx;
  logic [7:0] fcs_hi;
  logic       fcs_second;
  logic       info_last;
  logic [7:0] fr_addr;
  logic [7:0] fr_ctl0;
  logic [7:0] fr_ctl1;
  logic       fr_two;
  logic       fr_info;
  logic [15:0] tx_crc;
  logic [15:0] tx_crc_next;

  wire tx_busy  = tx_state != TX_IDLE;
  wire stuff_on = tx_state inside {TX_ADDR, TX_CTL0, TX_CTL1, TX_INFO, TX_FCS};
  wire crc_on   = stuff_on && tx_state != TX_FCS;
  wire ins      = (stuff_on || tx_state == TX_CLOSE) && ones_tx == `LFE_STUFF_RUN;
  wire out_bit  = !ins && shreg[0];
  wire adv      = i_enable && tx_busy && !ins;
  wire byte_end = adv && bits_left == 4'h1;
  wire idle_go  = i_enable && !tx_busy;
  wire tx_rej_start = idle_go && rej_pend;
  wire tx_i_start   = idle_go && !rej_pend && i_send_info && o_window_open;
  // unnumbered frames leave only on the host command
  wire tx_u_start   = idle_go && !rej_pend && !tx_i_start && i_transmit_unnumbered_cmd;
  wire tx_go        = tx_rej_start || tx_i_start || tx_u_start;
  wire [7:0] ucode  = (i_unnum_req.kind == UN_UI) ? `LFE_CTL_UI :
                      (i_unnum_req.kind == UN_TEST) ? `LFE_CTL_TEST : `LFE_CTL_XID;
  assign o_tx_idle  = !tx_busy;
  assign o_tx_ready = byte_end && want_info;

  always_comb begin
    nxt_state = TX_IDLE;
    nxt_byte  = `LFE_MARK;
    want_info = 1'b0;
    case (tx_state)
      TX_OPEN: begin
        nxt_state = TX_ADDR;
        nxt_byte  = fr_addr;
      end
      TX_ADDR: begin
        nxt_state = TX_CTL0;
        nxt_byte  = fr_ctl0;
      end
      TX_CTL0: begin
        nxt_state = fr_two ? TX_CTL1 : (fr_info ? TX_INFO : TX_FCS);
        nxt_byte  = fr_ctl1;
      end
      TX_CTL1: nxt_state = fr_info ? TX_INFO : TX_FCS;
      TX_INFO: nxt_state = info_last ? TX_FCS : TX_INFO;
      TX_FCS: begin
        nxt_state = fcs_second ? TX_CLOSE : TX_FCS;
        nxt_byte  = fcs_second ? `LFE_FLAG : fcs_hi;
      end
      default: nxt_state = TX_IDLE;
    endcase
    if (nxt_state == TX_INFO) begin
      want_info = 1'b1;
      nxt_byte  = i_tx_data;
    end
    // fcs leaves bit 0 first from the reflected register
    if (nxt_state == TX_FCS && tx_state != TX_FCS) nxt_byte = ~tx_crc_next[7:0];
    // an info underrun cannot stall the line, so the frame is aborted
    if (want_info && !i_tx_valid) begin
      nxt_state = TX_ABORT;
      nxt_byte  = `LFE_MARK;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_state   <= TX_IDLE;
      shreg      <= `LFE_MARK;
      bits_left  <= 4'h0;
      ones_tx    <= 3'h0;
      o_txd      <= 1'b1;
      fcs_hi     <= 8'h00;
      fcs_second <= 1'b0;
      info_last  <= 1'b0;
    end else if (i_enable) begin
      o_txd <= tx_busy ? out_bit : 1'b1;
      // flag bits do not count toward stuffing
      ones_tx <= (stuff_on && out_bit) ? ones_tx + 3'h1 : 3'h0;
      if (tx_go) begin
        tx_state   <= TX_OPEN;
        shreg      <= `LFE_FLAG;
        bits_left  <= 4'h8;
        fcs_second <= 1'b0;
        info_last  <= 1'b0;
      end else if (byte_end) begin
        tx_state  <= nxt_state;
        shreg     <= nxt_byte;
        bits_left <= 4'h8;
        if (want_info && i_tx_valid) info_last <= i_tx_last;
        if (nxt_state == TX_FCS && tx_state != TX_FCS) fcs_hi <= ~tx_crc_next[15:8];
        if (tx_state == TX_FCS) fcs_second <= 1'b1;
      end else if (adv) begin
        shreg     <= {1'b1, shreg[7:1]};
        bits_left <= bits_left - 4'h1;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fr_addr <= 8'h00;
      fr_ctl0 <= 8'h00;
      fr_ctl1 <= 8'h00;
      fr_two  <= 1'b0;
      fr_info <= 1'b0;
    end else if (tx_rej_start) begin
      fr_addr <= i_param.addr_rsp;
      fr_ctl0 <= i_param.mod128 ? `LFE_CTL_REJ : {seq.vr[2:0], 1'b0, 4'(`LFE_CTL_REJ)};
      fr_ctl1 <= {seq.vr, 1'b0};
      fr_two  <= i_param.mod128;
      fr_info <= 1'b0;
    end else if (tx_i_start) begin
      fr_addr <= i_param.addr_cmd;
      fr_ctl0 <= i_param.mod128 ? {seq.vs, 1'b0} : {seq.vr[2:0], 1'b0, seq.vs[2:0], 1'b0};
      fr_ctl1 <= {seq.vr, 1'b0};
      fr_two  <= i_param.mod128;
      fr_info <= 1'b1;
    end else if (tx_u_start) begin
      fr_addr <= i_unnum_req.is_cmd ? i_param.addr_cmd : i_param.addr_rsp;
      fr_ctl0 <= ucode | (i_unnum_req.pf ? `LFE_PF_MASK : 8'h00);
      fr_two  <= 1'b0;
      fr_info <= i_unnum_req.has_info;
    end
  end

  lapb_fcs16 u_tx_fcs (
    .i_clock  (i_clock),
    .i_rst_n  (i_rst_n),
    .i_enable (i_enable),
    .i_clear  (tx_go),
    .i_shift  (adv && crc_on),
    .i_bit    (shreg[0]),
    .o_crc    (tx_crc),
    .o_next   (tx_crc_next)
  );

  // sequence state: only frame traffic and link setup move it
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      seq      <= '0;
      rej_pend <= 1'b0;
    end else if (i_enable) begin
      if (i_link_setup) begin
        seq <= '0;
      end else begin
        if (tx_i_start) seq.vs <= (seq.vs + 7'h01) & mask;
        if (ack_frame) seq.va <= nr;
        if (rx_ok && is_i && in_order) seq.vr <= (seq.vr + 7'h01) & mask;
      end
      // out of order: reject pending, set wins
      if (rx_ok && is_i && !in_order) begin
        rej_pend <= 1'b1;
      end else if (tx_rej_start || i_link_setup) begin
        rej_pend <= 1'b0;
      end
    end
  end

  // timers in 0.1 s steps
  logic [TW-1:0] tick_cnt;
  logic [7:0]    t1_cnt;
  logic [7:0]    t2_cnt;
  logic [7:0]    retry;
  logic [11:0]   t3_cnt;
  logic          t2_run;
  wire tick = i_enable && tick_cnt == TICK_LAST;
  // t1 and t2 count 0.1 s steps
  wire t1_run  = outstanding != 7'h00 && i_param.t1 != 8'h00;
  wire t1_rst  = i_link_setup || tx_i_start || va_adv;
  wire t1_fire = tick && t1_run && !t1_rst && t1_cnt == i_param.t1 - 8'h01;
  wire t2_fire = tick && t2_run && i_param.t2 != 8'h00 && t2_cnt == i_param.t2 - 8'h01;
  wire [11:0] t3_lim = i_param.t3_coarse ? {4'h0, i_param.t3} * `LFE_COARSE_STEPS : {4'h0, i_param.t3};
  wire t3_fire = tick && !flag_ev && t3_lim != 12'h000 && t3_cnt == t3_lim - 12'h001;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tick_cnt     <= '0;
      t1_cnt       <= 8'h00;
      o_t1_expired <= 1'b0;
      t3_cnt       <= 12'h000;
      o_t3_expired <= 1'b0;
    end else if (i_enable) begin
      tick_cnt     <= (tick_cnt == TICK_LAST) ? '0 : tick_cnt + 1'b1;
      o_t1_expired <= t1_fire;
      o_t3_expired <= t3_fire;
      if (t1_rst || !t1_run || t1_fire) begin
        t1_cnt <= 8'h00;
      end else if (tick) begin
        t1_cnt <= t1_cnt + 8'h01;
      end
      if (flag_ev || t3_fire) begin
        t3_cnt <= 12'h000;
      end else if (tick) begin
        t3_cnt <= t3_cnt + 12'h001;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      t2_run            <= 1'b0;
      t2_cnt            <= 8'h00;
      o_t2_expired      <= 1'b0;
      retry             <= 8'h00;
      o_retry_exhausted <= 1'b0;
    end else if (i_enable) begin
      o_t2_expired <= t2_fire;
      // ack pending starts t2; a frame carrying n(r) stops it
      if (rx_ok && is_i && in_order) begin
        t2_run <= 1'b1;
        t2_cnt <= 8'h00;
      end else if (tx_i_start || tx_rej_start || i_link_setup || t2_fire) begin
        t2_run <= 1'b0;
      end else if (tick && t2_run) begin
        t2_cnt <= t2_cnt + 8'h01;
      end
      if (i_link_setup || va_adv) begin
        retry             <= 8'h00;
        o_retry_exhausted <= 1'b0;
      end else if (t1_fire) begin
        if (retry == i_param.n2) o_retry_exhausted <= 1'b1;
        else retry <= retry + 8'h01;
      end
    end
  end
endmodule

// ### tb/lapb_frame_link_engine_props.sv
// port assertions for the link frame engine
`timescale 1ns/1ps
module lapb_frame_link_engine_props (
  input wire logic                                    i_clock,
  input wire logic                                    i_rst_n,
  input wire lapb_frame_pkg::system_parameter_table_t i_param,
  input wire logic                                    i_link_setup,
  input wire logic                                    i_transmit_unnumbered_cmd,
  input wire logic                                    o_tx_ready,
  input wire logic                                    o_tx_idle,
  input wire logic                                    o_window_open,
  input wire logic                                    o_txd,
  input wire logic                                    o_rx_valid,
  input wire lapb_frame_pkg::seq_state_t              o_seq
);
  import lapb_frame_pkg::*;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  a_seq_reset: assert property ($rose(i_rst_n) |-> o_seq == '0)
    else $error("state not cleared by reset");
  a_seq_range: assert property (!i_param.mod128 |-> {o_seq.vs[6:3], o_seq.va[6:3], o_seq.vr[6:3]} == '0)
    else $error("state out of modulo 8 range");
  a_vs_step: assert property (!i_param.mod128 && $changed(o_seq.vs) |->
    $past(i_link_setup) || o_seq.vs[2:0] == $past(o_seq.vs[2:0]) + 3'h1) else $error("send variable jumped");
  a_vr_step: assert property (!i_param.mod128 && $changed(o_seq.vr) |->
    $past(i_link_setup) || o_seq.vr[2:0] == $past(o_seq.vr[2:0]) + 3'h1) else $error("receive variable jumped");
  a_window_size: assert property (!i_param.mod128 |-> o_window_open ==
    (3'(o_seq.vs[2:0] - o_seq.va[2:0]) < ((i_param.k > 7'h07) ? 7'h07 : i_param.k))) else $error("window wrong");
  a_ready_busy: assert property (o_tx_ready |-> !o_tx_idle)
    else $error("byte slot while idle");
  a_open_flag: assert property (o_tx_idle && i_transmit_unnumbered_cmd && i_param.protocol_option_param[2]
    |=> o_txd ##1 !o_txd ##1 o_txd [*6] ##1 !o_txd) else $error("no opening flag");
  a_idle_mark: assert property (o_tx_idle [*3] |-> o_txd)
    else $error("idle line not mark");
  a_rx_pulse: assert property (o_rx_valid |=> !o_rx_valid)
    else $error("octet strobe too long");
endmodule
bind lapb_frame_link_engine lapb_frame_link_engine_props u_lapb_frame_link_engine_props (.i_clock, .i_rst_n,
  .i_param, .i_link_setup, .i_transmit_unnumbered_cmd, .o_tx_ready, .o_tx_idle, .o_window_open, .o_txd,
  .o_rx_valid, .o_seq);

// ### tb/lapb_remote_station.sv
// remote station model: sends frames on the line, collects frames from the engine
`timescale 1ns/1ps
module lapb_remote_station (
  input  wire logic i_clock,
  input  wire logic i_txd,
  output logic      o_line
);
  logic [7:0] got [$];
  logic       q [$];
  logic [7:0] b;
  int         ones = 0, run = 0, n_rx = 0;
  initial o_line = 1'b1;
  function automatic logic [15:0] crc(input logic [7:0] f [$]);
    logic [15:0] c = 16'hffff;
    foreach (f[i]) for (int j = 0; j < 8; j++) c = (c >> 1) ^ ((c[0] ^ f[i][j]) ? 16'h8408 : 16'h0000);
    return c;
  endfunction
  task automatic put(input logic v, input logic stuff);
    @(posedge i_clock) o_line <= v;
    run = v ? run + 1 : 0;
    if (stuff && run == 5) begin
      @(posedge i_clock) o_line <= 1'b0;
      run = 0;
    end
  endtask
  task automatic send(input logic [7:0] a, c, input int mode);
    logic [7:0]  f [$];
    logic [15:0] r;
    f = {a};
    if (mode != 3) f = {a, c, 8'h55};
    // octets lsb first, fcs high term first; mode 1 spoils it
    r = ~crc(f) ^ 16'(mode == 1);
    f.push_back(r[7:0]);
    f.push_back(r[15:8]);
    for (int j = 0; j < 8; j++) put(j != 0 && j != 7, 1'b0);
    foreach (f[i]) for (int j = 0; j < 8; j++) if (mode != 2 || i < 2) put(f[i][j], 1'b1);
    if (mode == 2) repeat (7) put(1'b1, 1'b0);
    else begin
      if (mode == 4) for (int j = 0; j < 3; j++) put(j[0], 1'b1);
      for (int j = 0; j < 8; j++) put(j != 0 && j != 7, 1'b0);
    end
    @(posedge i_clock) o_line <= 1'b1;
  endtask
  // drop stuffed zeros, close on flag
  always @(posedge i_clock) begin
    if (i_txd === 1'b1) begin
      q.push_back(1'b1);
      ones++;
    end else if (ones == 5) ones = 0;
    else if (ones == 6 && q.size() >= 7) begin
      repeat (7) void'(q.pop_back());
      if (q.size() >= 32 && q.size() % 8 == 0) begin
        got.delete();
        for (int i = 0; i < q.size(); i += 8) begin
          for (int j = 0; j < 8; j++) b[j] = q[i + j];
          got.push_back(b);
        end
        n_rx++;
      end
      q.delete();
      ones = 0;
    end else begin
      if (ones > 5) q.delete();
      q.push_back(1'b0);
      ones = 0;
    end
  end
endmodule

// ### tb/lapb_frame_link_engine_tb_top.sv
// self-checking bench for the link frame engine
`timescale 1ns/1ps
module lapb_frame_link_engine_tb_top;
  import lapb_frame_pkg::*;
  logic                    i_clock = 1'b0;
  logic                    i_rst_n = 1'b0;
  system_parameter_table_t i_param;
  unnum_req_t              i_unnum_req;
  logic                    i_link_setup, i_transmit_unnumbered_cmd, i_send_info, i_tx_valid, i_tx_last, i_rxd;
  logic [7:0]              i_tx_data, o_rx_data;
  logic                    o_tx_ready, o_tx_idle, o_window_open, o_txd, o_rx_valid, o_rx_end;
  logic                    o_t1_expired, o_t2_expired, o_t3_expired, o_retry_exhausted;
  rx_status_t              o_rx_status;
  seq_state_t              o_seq;
  logic [7:0]              g [$];
  logic [7:0]              uc [3] = '{8'h03, 8'he3, 8'haf};
  rx_kind_t                rk [3] = '{RK_UI, RK_TEST, RK_XID};
  int                      n_fail = 0, checked = 0, cyc = 0;
  always #50 i_clock = ~i_clock;
  // short tick keeps timer runs brief
  lapb_frame_link_engine #(.TICK_CYCLES(8)) u_lapb_frame_link_engine (.i_enable(1'b1), .*);
  lapb_remote_station u_lapb_remote_station (.i_clock, .i_txd(o_txd), .o_line(i_rxd));
  task automatic chk(input string what, input logic [15:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end
  // go: 0 unnumbered command, 1 info frame, 2 await a frame the engine starts itself
  task automatic tx_case(input int go, input unnum_kind_t k, input logic [7:0] a, c);
    int n = u_lapb_remote_station.n_rx;
    for (int i = 0; i < 20 && !o_tx_idle; i++) @(posedge i_clock);
    i_unnum_req <= '{k, 1'b1, 1'b0, 1'b1};
    i_transmit_unnumbered_cmd <= (go == 0);
    i_send_info <= (go == 1);
    i_tx_data <= 8'hff;
    i_tx_valid <= (go != 2);
    i_tx_last <= 1'b0;
    @(posedge i_clock);
    i_transmit_unnumbered_cmd <= 1'b0;
    i_send_info <= 1'b0;
    for (int i = 0; i < 400 && u_lapb_remote_station.n_rx == n; i++) begin
      if (o_tx_ready && i_tx_valid) begin
        i_tx_valid <= !i_tx_last;
        i_tx_last <= 1'b1;
        i_tx_data <= 8'h3e;
      end
      @(posedge i_clock);
    end
    g = u_lapb_remote_station.got;
    chk("frame seen", 16'(u_lapb_remote_station.n_rx - n), 16'h0001);
    chk("frame size", 16'(g.size()), (go == 2) ? 16'h0004 : 16'h0006);
    chk("address", 16'(g[0]), 16'(a));
    chk("control", 16'(g[1]), 16'(c));
    if (go != 2) chk("info", {g[2], g[3]}, 16'hff3e);
    chk("fcs residue", u_lapb_remote_station.crc(g), 16'hf0b8);
    $display("tx test %0d done", go);
  endtask
  task automatic rx_case(input logic [7:0] a, c, input int mode, input logic good, input rx_kind_t k);
    seq_state_t s = o_seq;
    u_lapb_remote_station.send(a, c, mode);
    for (int i = 0; i < 40 && !o_rx_end; i++) @(posedge i_clock);
    chk("rx end", 16'(o_rx_end), 16'h0001);
    chk("rx good", 16'(o_rx_status.good), 16'(good));
    if (good) chk("rx kind", 16'(o_rx_status.kind), 16'(k));
    if (good) chk("rx data", 16'(o_rx_data), 16'h0055);
    if (k != RK_I) chk("state kept", 16'(o_seq !== s), 16'h0000);
    $display("rx test %h %h %0d done", a, c, mode);
  endtask
  initial begin
    i_param = '0;
    i_param.protocol_option_param = 8'h04;
    // host keeps k within the modulo 8 limit
    i_param.k = 7'h07;
    i_param.t1 = 8'h01;
    i_param.max_info_octets = 14'h0010;
    i_param.addr_cmd = 8'h01;
    i_param.addr_rsp = 8'h03;
    i_param.t3 = 8'h01;
    i_unnum_req = '0;
    {i_link_setup, i_transmit_unnumbered_cmd, i_send_info, i_tx_valid, i_tx_last, i_tx_data} = '0;
    repeat (12) @(posedge i_clock);
    i_rst_n <= 1'b1;
    @(posedge i_clock);
    chk("idle line", 16'(o_txd), 16'h0001);
    for (int i = 0; i < 3; i++) tx_case(0, unnum_kind_t'(i), 8'h01, uc[i]);
    for (int i = 0; i < 3; i++) rx_case(8'h01, uc[i], 0, 1'b1, rk[i]);
    // bad fcs, abort, short frame, stray bits
    for (int i = 1; i < 5; i++) rx_case(8'h01, 8'h03, i, 1'b0, RK_UI);
    rx_case(8'h7f, 8'h03, 0, 1'b0, RK_UI);
    i_link_setup <= 1'b1;
    @(posedge i_clock);
    i_link_setup <= 1'b0;
    tx_case(1, UN_UI, 8'h01, 8'h00);
    chk("send var", 16'(o_seq.vs), 16'h0001);
    chk("retry limit", 16'(o_retry_exhausted), 16'h0001);
    rx_case(8'h01, 8'h22, 0, 1'b1, RK_I);
    tx_case(2, UN_UI, 8'h03, 8'h09);
    rx_case(8'h01, 8'h20, 0, 1'b1, RK_I);
    chk("ack var", 16'(o_seq.va), 16'h0001);
    chk("recv var", 16'(o_seq.vr), 16'h0001);
    chk("retry clear", 16'(o_retry_exhausted), 16'h0000);
    i_param.protocol_option_param <= 8'h00;
    rx_case(8'h01, 8'h03, 0, 1'b0, RK_UI);
    chk("undefined", 16'(o_rx_status.undefined), 16'h0001);
    for (int i = 0; i < 40 && !o_t3_expired; i++) @(posedge i_clock);
    chk("t3 expiry", 16'(o_t3_expired), 16'h0001);
    summarize();
  end
endmodule
